// ===== pmda_core_model.sv
// Core model issuing random fetch requests
`timescale 1ns/1ps
module pmda_core_model (
   input wire logic clk,
   input wire logic run,
   output logic adv,
   output logic jmp,
   output logic [12:0] jaddr,
   output logic intr
);
   // -------------------------------------------------------------
   // Random requests, changed just after each edge
   // -------------------------------------------------------------
   initial begin
      adv = 1'b0;
      jmp = 1'b0;
      jaddr = 13'h0000;
      intr = 1'b0;
      forever begin
         @(posedge clk);
         adv <= run && ($urandom_range(0, 1) == 1);
         jmp <= run && ($urandom_range(0, 7) == 0);
         intr <= run && ($urandom_range(0, 15) == 0);
         // Top address often, so wrap and roll-over are hit
         jaddr <= ($urandom_range(0, 3) == 0) ? 13'h1FFF : 13'($urandom);
      end
   end
endmodule : pmda_core_model

// ===== pmda_pkg.sv
// Package of constants for program and data memory addressing
package pmda_pkg;
   // -------------------------------------------------------------
   // Program memory
   // -------------------------------------------------------------
   localparam int PC_WIDTH = 13;
   localparam int PWORD_WIDTH = 14;
   localparam int PMEM_WORDS_8K = 8192;
   localparam int PMEM_WORDS_4K = 4096;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] INT_VECTOR = 13'h0004;
   // -------------------------------------------------------------
   // Data memory
   // -------------------------------------------------------------
   localparam int DADDR_WIDTH = 9;
   localparam int OFFSET_WIDTH = 7;
   localparam int STATUS_BANK_HI_BIT = 6;
   localparam int STATUS_BANK_LO_BIT = 5;
   localparam logic [6:0] BANK_TOP = 7'h7F;
   localparam logic [6:0] GPR_BASE = 7'h20;
   localparam logic [6:0] SHARED_BASE = 7'h70;
   localparam logic [6:0] OFS_INDIRECT = 7'h00;
   localparam logic [6:0] OFS_PCL = 7'h02;
   localparam logic [6:0] OFS_STATUS = 7'h03;
   localparam logic [6:0] OFS_POINTER = 7'h04;
   localparam logic [6:0] OFS_PCLATH = 7'h0A;
   localparam logic [6:0] OFS_INTCON = 7'h0B;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [4:0] PCLATH_RESET = 5'h00;
   localparam logic [7:0] INTCON_RESET = 8'h00;

   typedef enum logic [1:0] {
      FETCH_RESET = 2'b00,
      FETCH_RUN = 2'b01,
      FETCH_VECTOR = 2'b10
   } pmda_fetch_type;
endpackage : pmda_pkg

// ===== pmda_ram.sv
// General purpose RAM with registered read data
`timescale 1ns/1ps
module pmda_ram #(
   parameter int DEPTH = 512,
   parameter int AW = 9,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : pmda_ram

// ===== pmda_top.sv
// Program counter and banked data memory addressing for the core
// Notes on behaviour
// - Program fetch and data access use separate ports, usable together.
// - The program counter is 13 bits wide over 14-bit program words.
// - Implemented program memory is 8K or 4K words by build parameter.
// - Program addresses beyond the implemented size wrap around.
// - After reset fetch starts at address 0000h.
// - A taken interrupt sends fetch to address 0004h.
// - Status bits 6 and 5 pick data bank 0 to 3 for direct access; indirect takes bit 6 and pointer bit 7.
// - Banks span offsets to 7Fh, special registers low, RAM above.
// - Selected special registers answer the same in every bank.
// - Data is reached by direct offset or through the pointer register.
`timescale 1ns/1ps
module pmda_top #(
   parameter int PMEM_WORDS = pmda_pkg::PMEM_WORDS_8K
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic FETCH_ADV,
   input wire logic JUMP_VALID,
   input wire logic [12:0] JUMP_ADDR,
   input wire logic INT_TAKE,
   output logic [12:0] FETCH_ADDR,
   input wire logic DATA_RD,
   input wire logic DATA_WR,
   input wire logic DATA_INDIRECT,
   input wire logic [6:0] DATA_OFFSET,
   input wire logic [7:0] DATA_WDATA,
   output logic [7:0] DATA_RDATA,
   output logic [8:0] DATA_ADDR,
   output logic [7:0] STATUS_VALUE
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   localparam logic [12:0] PC_MASK = 13'(PMEM_WORDS - 1);

   function automatic logic [12:0] wrap_pc(input logic [12:0] a);
      return a & PC_MASK;
   endfunction : wrap_pc

   // Mirrored registers are identified by offset alone, ignoring bank
   function automatic logic is_mirrored(input logic [6:0] ofs);
      return ofs == pmda_pkg::OFS_INDIRECT || ofs == pmda_pkg::OFS_PCL ||
         ofs == pmda_pkg::OFS_STATUS || ofs == pmda_pkg::OFS_POINTER ||
         ofs == pmda_pkg::OFS_PCLATH || ofs == pmda_pkg::OFS_INTCON ||
         ofs >= pmda_pkg::SHARED_BASE;
   endfunction : is_mirrored

   // -------------------------------------------------------------
   // Program counter
   // -------------------------------------------------------------
   pmda_pkg::pmda_fetch_type st_q, st_d;
   logic [12:0] pc_q, pc_d;

   always_comb begin
      st_d = st_q;
      pc_d = pc_q;
      unique case (st_q)
         pmda_pkg::FETCH_RESET: begin
            pc_d = pmda_pkg::RESET_VECTOR;
            st_d = pmda_pkg::FETCH_RUN;
         end
         pmda_pkg::FETCH_RUN, pmda_pkg::FETCH_VECTOR: begin
            st_d = pmda_pkg::FETCH_RUN;
            // Interrupt outranks a jump in the same cycle
            if (INT_TAKE) begin
               pc_d = pmda_pkg::INT_VECTOR;
               st_d = pmda_pkg::FETCH_VECTOR;
            end else if (JUMP_VALID) begin
               pc_d = wrap_pc(JUMP_ADDR);
            end else if (FETCH_ADV) begin
               pc_d = wrap_pc(pc_q + 13'h0001);
            end
         end
         default: begin
            st_d = pmda_pkg::FETCH_RESET;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         st_q <= pmda_pkg::FETCH_RESET;
         pc_q <= pmda_pkg::RESET_VECTOR;
      end else begin
         st_q <= st_d;
         pc_q <= pc_d;
      end
   end

   assign FETCH_ADDR = pc_q;

   // -------------------------------------------------------------
   // Core special registers
   // -------------------------------------------------------------
   logic [7:0] status_q, status_d;
   logic [7:0] ptr_q, ptr_d;
   logic [4:0] pclath_q, pclath_d;
   logic [7:0] intcon_q, intcon_d;
   logic [1:0] bank_sel;
   logic bank_select_high;
   logic bank_select_low;
   logic [8:0] addr;
   logic [6:0] ofs;
   logic is_sfr;
   logic [8:0] ram_addr;
   logic [7:0] ram_rdata;
   logic [7:0] sfr_rd_d, sfr_rd_q;
   logic sel_ram_d, sel_ram_q;

   assign bank_select_high = status_q[pmda_pkg::STATUS_BANK_HI_BIT];
   assign bank_select_low = status_q[pmda_pkg::STATUS_BANK_LO_BIT];
   assign bank_sel = {bank_select_high, bank_select_low};

   // Indirect uses the pointer plus the high bank bit for bit 8
   always_comb begin
      if (DATA_INDIRECT) begin
         addr = {bank_select_high, ptr_q};
      end else begin
         addr = {bank_sel, DATA_OFFSET};
      end
   end

   assign ofs = addr[6:0];
   assign is_sfr = ofs < pmda_pkg::GPR_BASE;
   // Mirrors fold onto bank 0 storage
   assign ram_addr = is_mirrored(ofs) ? {2'b00, ofs} : addr;

   always_comb begin
      status_d = status_q;
      ptr_d = ptr_q;
      pclath_d = pclath_q;
      intcon_d = intcon_q;
      sfr_rd_d = 8'h00;
      // Idle cycles read back as zero, not as stale RAM data
      sel_ram_d = DATA_RD && !is_sfr;
      // Indirect through offset 0 is no physical register
      if (DATA_WR && is_sfr && !(DATA_INDIRECT && ofs ==
            pmda_pkg::OFS_INDIRECT)) begin
         unique case (ofs)
            pmda_pkg::OFS_STATUS: status_d = DATA_WDATA;
            pmda_pkg::OFS_POINTER: ptr_d = DATA_WDATA;
            pmda_pkg::OFS_PCLATH: pclath_d = DATA_WDATA[4:0];
            pmda_pkg::OFS_INTCON: intcon_d = DATA_WDATA;
            default: ;
         endcase
      end
      if (DATA_RD && is_sfr) begin
         unique case (ofs)
            pmda_pkg::OFS_PCL: sfr_rd_d = pc_q[7:0];
            pmda_pkg::OFS_STATUS: sfr_rd_d = status_q;
            pmda_pkg::OFS_POINTER: sfr_rd_d = ptr_q;
            pmda_pkg::OFS_PCLATH: sfr_rd_d = {3'h0, pclath_q};
            pmda_pkg::OFS_INTCON: sfr_rd_d = intcon_q;
            default: sfr_rd_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         status_q <= pmda_pkg::STATUS_RESET;
         ptr_q <= pmda_pkg::POINTER_RESET;
         pclath_q <= pmda_pkg::PCLATH_RESET;
         intcon_q <= pmda_pkg::INTCON_RESET;
         sfr_rd_q <= 8'h00;
         sel_ram_q <= 1'b0;
      end else begin
         status_q <= status_d;
         ptr_q <= ptr_d;
         pclath_q <= pclath_d;
         intcon_q <= intcon_d;
         sfr_rd_q <= sfr_rd_d;
         sel_ram_q <= sel_ram_d;
      end
   end

   // -------------------------------------------------------------
   // General purpose RAM
   // -------------------------------------------------------------
   pmda_ram #(
      .DEPTH(512),
      .AW(pmda_pkg::DADDR_WIDTH),
      .DW(8)
   ) u_ram (
      .clk(CLK_SYS),
      .we(DATA_WR && !is_sfr),
      .waddr(ram_addr),
      .wdata(DATA_WDATA),
      .raddr(ram_addr),
      .rdata(ram_rdata)
   );

   assign DATA_RDATA = sel_ram_q ? ram_rdata : sfr_rd_q;
   assign DATA_ADDR = addr;
   assign STATUS_VALUE = status_q;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   property p_fetch_sep;
      @(posedge CLK_SYS) disable iff (RST)
      (st_q == pmda_pkg::FETCH_RUN && DATA_WR && !INT_TAKE && !JUMP_VALID
         && FETCH_ADV) |=> FETCH_ADDR == wrap_pc($past(FETCH_ADDR) + 13'h1);
   endproperty
   a_fetch_sep: assert property (p_fetch_sep)
      else $error("fetch stalled by data access");

   property p_pc_width;
      @(posedge CLK_SYS) disable iff (RST)
      st_q != pmda_pkg::FETCH_RESET && FETCH_ADV && !JUMP_VALID && !INT_TAKE
         && FETCH_ADDR == PC_MASK |=> FETCH_ADDR == 13'h0000;
   endproperty
   a_pc_width: assert property (p_pc_width)
      else $error("pc wrapped incorrectly at top");

   property p_pc_range;
      @(posedge CLK_SYS) disable iff (RST)
      FETCH_ADDR <= PC_MASK;
   endproperty
   a_pc_range: assert property (p_pc_range)
      else $error("pc outside implemented memory");

   property p_jump_wrap;
      @(posedge CLK_SYS) disable iff (RST)
      st_q != pmda_pkg::FETCH_RESET && JUMP_VALID && !INT_TAKE
         |=> FETCH_ADDR == ($past(JUMP_ADDR) & PC_MASK);
   endproperty
   a_jump_wrap: assert property (p_jump_wrap)
      else $error("jump not wrapped");

   property p_reset_vec;
      @(posedge CLK_SYS) $fell(RST) |-> FETCH_ADDR == 13'h0000;
   endproperty
   a_reset_vec: assert property (p_reset_vec)
      else $error("fetch not at reset vector");

   property p_int_vec;
      @(posedge CLK_SYS) disable iff (RST)
      st_q != pmda_pkg::FETCH_RESET && INT_TAKE |=> FETCH_ADDR == 13'h0004;
   endproperty
   a_int_vec: assert property (p_int_vec)
      else $error("interrupt vector missed");

   property p_direct_addr;
      @(posedge CLK_SYS) disable iff (RST)
      !DATA_INDIRECT |-> DATA_ADDR == {STATUS_VALUE[6:5], DATA_OFFSET};
   endproperty
   a_direct_addr: assert property (p_direct_addr)
      else $error("direct address wrong");

   property p_sfr_no_ram;
      @(posedge CLK_SYS) disable iff (RST)
      DATA_RD && is_sfr && ofs == pmda_pkg::OFS_STATUS
         |=> DATA_RDATA == $past(status_q);
   endproperty
   a_sfr_no_ram: assert property (p_sfr_no_ram)
      else $error("status read wrong");

   property p_indirect;
      @(posedge CLK_SYS) disable iff (RST)
      DATA_INDIRECT |-> DATA_ADDR == {STATUS_VALUE[6], ptr_q};
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("indirect address wrong");

   property p_pcl_read;
      @(posedge CLK_SYS) disable iff (RST)
      DATA_RD && ofs == pmda_pkg::OFS_PCL
         |=> DATA_RDATA == $past(FETCH_ADDR[7:0]);
   endproperty
   a_pcl_read: assert property (p_pcl_read)
      else $error("program counter low read wrong");
endmodule : pmda_top

// ===== testbench.sv
// Self-checking testbench for program and data addressing
`timescale 1ns/1ps
module testbench;
   // Small variant, so jumps above it must wrap
   localparam int WORDS = pmda_pkg::PMEM_WORDS_4K;
   logic CLK_SYS = 1'b0;
   logic RST, FETCH_ADV, JUMP_VALID, INT_TAKE, DATA_RD, DATA_WR;
   logic DATA_INDIRECT;
   logic [12:0] JUMP_ADDR, FETCH_ADDR;
   logic [12:0] exp_pc = pmda_pkg::RESET_VECTOR;
   logic [6:0] DATA_OFFSET, o;
   logic [7:0] DATA_WDATA, DATA_RDATA, STATUS_VALUE, rv, p;
   logic [8:0] DATA_ADDR;
   logic [7:0] vals [4];
   logic run = 1'b0;
   logic mon = 1'b0;
   int bad_count = 0;
   int checks_done = 0;

   always #2 CLK_SYS = ~CLK_SYS;

   pmda_core_model pmda_core_model_i (.clk(CLK_SYS), .run(run),
      .adv(FETCH_ADV), .jmp(JUMP_VALID), .jaddr(JUMP_ADDR), .intr(INT_TAKE));
   pmda_top #(.PMEM_WORDS(WORDS)) pmda_top_i (.CLK_SYS(CLK_SYS), .RST(RST),
      .FETCH_ADV(FETCH_ADV), .JUMP_VALID(JUMP_VALID), .JUMP_ADDR(JUMP_ADDR),
      .INT_TAKE(INT_TAKE), .FETCH_ADDR(FETCH_ADDR), .DATA_RD(DATA_RD),
      .DATA_WR(DATA_WR), .DATA_INDIRECT(DATA_INDIRECT),
      .DATA_OFFSET(DATA_OFFSET), .DATA_WDATA(DATA_WDATA),
      .DATA_RDATA(DATA_RDATA), .DATA_ADDR(DATA_ADDR),
      .STATUS_VALUE(STATUS_VALUE));

   // -------------------------------------------------------------
   // Expectation and reporting helpers
   // -------------------------------------------------------------
   function automatic logic [12:0] next_pc(input logic [12:0] pc,
      input logic a, input logic j, input logic [12:0] ja, input logic i);
      if (i) return pmda_pkg::INT_VECTOR;
      if (j) return 13'(int'(ja) % WORDS);
      if (a) return 13'((int'(pc) + 1) % WORDS);
      return pc;
   endfunction : next_pc

   task automatic chk(input string nm, input logic [12:0] ev,
      input logic [12:0] got);
      checks_done++;
      if (got !== ev) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, ev, got);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // One data access; address checked only for banked RAM offsets 20h to 6Fh
   task automatic acc(input logic w, input logic ind, input logic [6:0] off,
      input logic [7:0] wd, input logic [8:0] ea);
      @(posedge CLK_SYS);
      DATA_WR <= w;
      DATA_RD <= ~w;
      DATA_INDIRECT <= ind;
      DATA_OFFSET <= off;
      DATA_WDATA <= wd;
      #1;
      if (ea[6:0] >= 7'h20 && ea[6:0] < 7'h70)
         chk("data_addr", 13'(ea), 13'(DATA_ADDR));
      @(posedge CLK_SYS);
      DATA_WR <= 1'b0;
      DATA_RD <= 1'b0;
      #1;
      rv = DATA_RDATA;
   endtask : acc

   task automatic setb(input logic [1:0] b);
      acc(1'b1, 1'b0, pmda_pkg::OFS_STATUS, {1'b0, b, 5'h18}, {b, 7'h03});
      chk("bank_bits", 13'(b), 13'(STATUS_VALUE[6:5]));
   endtask : setb

   // Fetch runs beside data traffic, so both paths work together
   always @(posedge CLK_SYS) begin
      if (mon) begin
         chk("pc", exp_pc, FETCH_ADDR);
         exp_pc = next_pc(exp_pc, FETCH_ADV, JUMP_VALID, JUMP_ADDR, INT_TAKE);
      end
   end

   initial begin
      repeat (20000) @(posedge CLK_SYS);
      bad_count++;
      final_report();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(32'hBFA8013D));
      RST = 1'b1;
      {DATA_RD, DATA_WR, DATA_INDIRECT} = 3'h0;
      DATA_OFFSET = 7'h00;
      DATA_WDATA = 8'h00;
      repeat (8) @(posedge CLK_SYS);
      RST <= 1'b0;
      @(posedge CLK_SYS);
      #1;
      chk("fetch_addr", pmda_pkg::RESET_VECTOR, FETCH_ADDR);
      chk("status", 13'(pmda_pkg::STATUS_RESET),
         13'(STATUS_VALUE));
      @(posedge CLK_SYS);
      run <= 1'b1;
      mon <= 1'b1;
      acc(1'b0, 1'b0, 7'h01, 8'h00, 9'h001);
      chk("unimpl", 13'h0000, 13'(rv));
      o = 7'($urandom_range(32, 111));
      for (int b = 0; b < 4; b++) begin
         setb(2'(b));
         vals[b] = 8'($urandom);
         acc(1'b1, 1'b0, o, vals[b], {2'(b), o});
      end
      for (int b = 3; b >= 0; b--) begin
         setb(2'(b));
         acc(1'b0, 1'b0, o, 8'h00, {2'(b), o});
         chk("bank_ram", 13'(vals[b]), 13'(rv));
      end
      setb(2'h3);
      acc(1'b1, 1'b0, 7'h75, 8'hA5, 9'h175);
      setb(2'h0);
      acc(1'b0, 1'b0, 7'h75, 8'h00, 9'h075);
      chk("shared", 13'h00A5, 13'(rv));
      setb(2'h1);
      acc(1'b1, 1'b0, pmda_pkg::OFS_PCLATH, 8'hFF, 9'h08A);
      setb(2'h2);
      acc(1'b0, 1'b0, pmda_pkg::OFS_PCLATH, 8'h00, 9'h10A);
      chk("pclath", 13'h001F, 13'(rv));
      // Status written through bank 1 reads back in bank 2
      acc(1'b0, 1'b0, pmda_pkg::OFS_STATUS, 8'h00, 9'h103);
      chk("status_rd", 13'h0058, 13'(rv));
      acc(1'b0, 1'b0, pmda_pkg::OFS_PCL, 8'h00, 9'h102);
      p = {1'b1, o};
      acc(1'b1, 1'b0, pmda_pkg::OFS_POINTER, p, 9'h104);
      acc(1'b0, 1'b1, 7'h00, 8'h00, {1'b1, p});
      chk("indirect", 13'(vals[3]), 13'(rv));
      acc(1'b1, 1'b1, 7'h00, 8'h3C, {1'b1, p});
      setb(2'h3);
      acc(1'b0, 1'b0, o, 8'h00, {2'h3, o});
      chk("ind_write", 13'h003C, 13'(rv));
      repeat (50) @(posedge CLK_SYS);
      final_report();
   end
endmodule : testbench
